// File: rtl/dccf_pkg.sv
// Shared constants, field layouts and decode helpers for the DMA channel
package dccf_pkg;

	// ********************************************************************
	// Register map (byte offsets)
	// ********************************************************************
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_SRC = 5'h04;
	localparam logic [4:0] OFS_DST = 5'h08;
	localparam logic [4:0] OFS_LLI = 5'h0C;
	localparam logic [4:0] OFS_CFG = 5'h10;
	localparam logic [4:0] OFS_STAT = 5'h14;

	// Field positions of the config and status words
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_FLOW_LSB = 11;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_PDONE_BIT = 1;

	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;
	localparam logic [2:0] FLOW_RST = 3'h0;

	// Item width codes
	localparam logic [2:0] WID_BYTE = 3'h0;
	localparam logic [2:0] WID_HALF = 3'h1;
	localparam logic [2:0] WID_WORD = 3'h2;

	// Linked-list item: four words, source, dest, next item, control
	localparam logic [1:0] LLI_LAST_IDX = 2'h3;
	localparam logic [31:0] LLI_STEP = 32'h0000_0004;

	// ********************************************************************
	// Carriers
	// ********************************************************************
	typedef struct packed {
		logic tc_irq_en;
		logic [2:0] prot;
		logic dest_increment_enable;
		logic source_increment_enable;
		logic [1:0] rsvd;
		logic [2:0] dest_item_width;
		logic [2:0] source_item_width;
		logic [2:0] dest_burst_length;
		logic [2:0] source_burst_length;
		logic [11:0] transfer_item_count;
	} dccf_ctrl_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dccf_mreq_t;

	// ********************************************************************
	// Decode helpers
	// ********************************************************************
	// Reserved width codes fall back to a byte
	function automatic logic [2:0] item_bytes(input logic [2:0] code);
		case (code)
			WID_HALF: item_bytes = 3'h2;
			WID_WORD: item_bytes = 3'h4;
			default: item_bytes = 3'h1;
		endcase
	endfunction

	// Burst code to item count; 000 is a single transfer
	function automatic logic [8:0] burst_len(input logic [2:0] code);
		case (code)
			3'h0: burst_len = 9'h001;
			3'h1: burst_len = 9'h004;
			3'h2: burst_len = 9'h008;
			3'h3: burst_len = 9'h010;
			3'h4: burst_len = 9'h020;
			3'h5: burst_len = 9'h040;
			3'h6: burst_len = 9'h080;
			default: burst_len = 9'h100;
		endcase
	endfunction

	// Source side is a peripheral for these transfer types
	function automatic logic src_is_periph(input logic [2:0] f);
		src_is_periph = (f == 3'h2) || (f == 3'h3) || (f == 3'h4) ||
			(f == 3'h6) || (f == 3'h7);
	endfunction

	// Destination side is a peripheral for these transfer types
	function automatic logic dst_is_periph(input logic [2:0] f);
		dst_is_periph = (f == 3'h1) || (f == 3'h3) || (f == 3'h4) ||
			(f == 3'h5) || (f == 3'h7);
	endfunction

	// Byte-enable merge for bus writes
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

endpackage

// File: rtl/dccf_pack.sv
// Byte packing buffer between source reads and destination writes
`timescale 1ns/1ps
module dccf_pack (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Control
	input wire logic clr_i,
	// Fill side
	input wire logic push_i,
	input wire logic [31:0] push_data_i,
	input wire logic [2:0] push_bytes_i,
	// Drain side
	input wire logic pop_i,
	input wire logic [2:0] pop_bytes_i,
	output logic [31:0] data_o,
	output logic [2:0] count_o
);

	typedef struct packed {
		logic [31:0] bytes;
		logic [2:0] cnt;
	} dccf_pk_t;

	dccf_pk_t s_q, s_d;
	logic [31:0] mask;

	// Keep only the bytes of the incoming item
	always_comb begin
		case (push_bytes_i)
			3'h1: mask = 32'h0000_00FF;
			3'h2: mask = 32'h0000_FFFF;
			default: mask = 32'hFFFF_FFFF;
		endcase
	end

	// Oldest byte sits in the low lane; FSM never pushes and pops together
	always_comb begin
		s_d = s_q;
		if (clr_i) begin
			s_d = '0;
		end else if (push_i) begin
			s_d.bytes = s_q.bytes |
				((push_data_i & mask) << {s_q.cnt, 3'b000});
			s_d.cnt = s_q.cnt + push_bytes_i;
		end else if (pop_i) begin
			s_d.bytes = s_q.bytes >> {pop_bytes_i, 3'b000};
			s_d.cnt = s_q.cnt - pop_bytes_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign data_o = s_q.bytes;
	assign count_o = s_q.cnt;

endmodule

// File: rtl/dccf_channel.sv
// One DMA channel: control word, packing engine, linked-list reload
`timescale 1ns/1ps
module dccf_channel (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Avalon-MM register slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// System bus master
	output dccf_pkg::dccf_mreq_t mem_o,
	input wire logic mem_ack_i,
	input wire logic [31:0] mem_rdata_i,
	// Peripheral request pins
	input wire logic src_dreq_i,
	input wire logic dst_dreq_i,
	input wire logic periph_last_i,
	// Channel state
	output logic busy_o
);

	typedef enum logic [2:0] {
		ST_IDLE, ST_RUN, ST_RD, ST_WR, ST_LLI
	} dccf_st_t;

	typedef struct packed {
		logic wait_n;
		logic [31:0] rdata;
		dccf_pkg::dccf_ctrl_t ctrl;
		logic [31:0] src;
		logic [31:0] dst;
		logic [31:0] lli;
		logic en;
		logic [2:0] flow;
		logic [11:0] left;
		logic [11:0] done_cnt;
		logic pdone;
		logic [8:0] sb_left;
		logic [8:0] db_left;
		logic [1:0] lli_idx;
		dccf_pkg::dccf_mreq_t mreq;
		dccf_st_t st;
		logic [2:0] sync1;
		logic [2:0] sync2;
	} dccf_state_t;

	dccf_state_t s_q, s_d;

	// Packing buffer hookup
	logic pk_clr, pk_push, pk_pop;
	logic [31:0] pk_data;
	logic [2:0] pk_cnt;
	logic [2:0] sbytes, dbytes;
	logic sp, dp, src_more, bus_req, bus_hit;
	logic [31:0] cfg_word, wmerge;

	dccf_pack u_pack (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.clr_i(pk_clr),
		.push_i(pk_push),
		.push_data_i(mem_rdata_i),
		.push_bytes_i(sbytes),
		.pop_i(pk_pop),
		.pop_bytes_i(dbytes),
		.data_o(pk_data),
		.count_o(pk_cnt)
	);

	// ********************************************************************
	// Decode of the live control word
	// ********************************************************************
	always_comb begin
		sbytes = dccf_pkg::item_bytes(s_q.ctrl.source_item_width);
		dbytes = dccf_pkg::item_bytes(s_q.ctrl.dest_item_width);
		sp = dccf_pkg::src_is_periph(s_q.flow);
		dp = dccf_pkg::dst_is_periph(s_q.flow);
		// Peripheral flow ends on its last signal, else on the count
		src_more = s_q.flow[2] ? !s_q.pdone : (s_q.left != 12'h000);
		cfg_word = '0;
		cfg_word[dccf_pkg::CFG_EN_BIT] = s_q.en;
		cfg_word[dccf_pkg::CFG_FLOW_LSB +: 3] = s_q.flow;
		bus_req = (avs_read || avs_write) && s_q.wait_n;
		bus_hit = bus_req && avs_write;
		wmerge = avs_writedata;
	end

	// ********************************************************************
	// Next state: register slave, then channel engine
	// ********************************************************************
	always_comb begin
		s_d = s_q;
		pk_clr = 1'b0;
		pk_push = 1'b0;
		pk_pop = 1'b0;
		// Pin synchronisers; only stage two is read
		s_d.sync1 = {periph_last_i, dst_dreq_i, src_dreq_i};
		s_d.sync2 = s_q.sync1;

		// One wait cycle, then a single ready cycle per access
		s_d.wait_n = !bus_req;
		if (bus_req && avs_read) begin
			if (avs_address == dccf_pkg::OFS_CTRL) begin
				// Count field shows destination progress
				s_d.rdata = {s_q.ctrl[31:12], s_q.done_cnt};
			end else if (avs_address == dccf_pkg::OFS_SRC) begin
				s_d.rdata = s_q.src;
			end else if (avs_address == dccf_pkg::OFS_DST) begin
				s_d.rdata = s_q.dst;
			end else if (avs_address == dccf_pkg::OFS_LLI) begin
				s_d.rdata = s_q.lli;
			end else if (avs_address == dccf_pkg::OFS_CFG) begin
				s_d.rdata = cfg_word;
			end else if (avs_address == dccf_pkg::OFS_STAT) begin
				s_d.rdata = '0;
				s_d.rdata[dccf_pkg::STAT_BUSY_BIT] = (s_q.st != ST_IDLE);
				s_d.rdata[dccf_pkg::STAT_PDONE_BIT] = s_q.pdone;
			end else begin
				s_d.rdata = '0;
			end
		end
		if (bus_hit) begin
			if (avs_address == dccf_pkg::OFS_CTRL) begin
				// Written count becomes the transfer total
				s_d.ctrl = dccf_pkg::be_merge(s_q.ctrl, wmerge,
					avs_byteenable);
				s_d.left = s_d.ctrl.transfer_item_count;
				s_d.done_cnt = '0;
			end else if (avs_address == dccf_pkg::OFS_SRC) begin
				s_d.src = dccf_pkg::be_merge(s_q.src, wmerge, avs_byteenable);
			end else if (avs_address == dccf_pkg::OFS_DST) begin
				s_d.dst = dccf_pkg::be_merge(s_q.dst, wmerge, avs_byteenable);
			end else if (avs_address == dccf_pkg::OFS_LLI) begin
				s_d.lli = dccf_pkg::be_merge(s_q.lli, wmerge, avs_byteenable)
					& 32'hFFFF_FFFC;
			end else if (avs_address == dccf_pkg::OFS_CFG) begin
				if (avs_byteenable[1]) begin
					s_d.flow = avs_writedata[dccf_pkg::CFG_FLOW_LSB +: 3];
				end
				if (avs_byteenable[0]) begin
					s_d.en = avs_writedata[dccf_pkg::CFG_EN_BIT];
					// Rising enable starts a fresh run
					if (avs_writedata[dccf_pkg::CFG_EN_BIT] && !s_q.en) begin
						s_d.left = s_q.ctrl.transfer_item_count;
						s_d.done_cnt = '0;
						s_d.pdone = 1'b0;
						s_d.sb_left = '0;
						s_d.db_left = '0;
						pk_clr = 1'b1;
					end
				end
			end
		end

		// Peripheral last signal; taken only while enabled, so the start clear wins
		if (s_q.en && s_q.sync2[2]) begin
			s_d.pdone = 1'b1;
		end

		case (s_q.st)
			ST_IDLE: begin
				if (s_d.en && !s_q.en) begin
					s_d.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!s_q.en) begin
					s_d.st = ST_IDLE;
				end else if (pk_cnt >= dbytes) begin
					// Enough bytes for one destination item
					if (dp && s_q.db_left == 9'h000) begin
						if (s_q.sync2[1]) begin
							s_d.db_left = dccf_pkg::burst_len(
								s_q.ctrl.dest_burst_length);
						end
					end else begin
						s_d.mreq.req = 1'b1;
						s_d.mreq.we = 1'b1;
						s_d.mreq.size = s_q.ctrl.dest_item_width[1:0];
						s_d.mreq.addr = s_q.dst;
						s_d.mreq.wdata = pk_data;
						s_d.st = ST_WR;
					end
				end else if (src_more) begin
					if (sp && s_q.sb_left == 9'h000) begin
						if (s_q.sync2[0]) begin
							s_d.sb_left = dccf_pkg::burst_len(
								s_q.ctrl.source_burst_length);
						end
					end else begin
						s_d.mreq.req = 1'b1;
						s_d.mreq.we = 1'b0;
						s_d.mreq.size = s_q.ctrl.source_item_width[1:0];
						s_d.mreq.addr = s_q.src;
						s_d.st = ST_RD;
					end
				end else begin
					// Packet over; leftover partial bytes are dropped
					pk_clr = 1'b1;
					if (s_q.lli != 32'h0000_0000) begin
						s_d.lli_idx = '0;
						s_d.mreq.req = 1'b1;
						s_d.mreq.we = 1'b0;
						s_d.mreq.size = dccf_pkg::WID_WORD[1:0];
						s_d.mreq.addr = s_q.lli;
						s_d.st = ST_LLI;
					end else begin
						s_d.en = 1'b0;
						s_d.st = ST_IDLE;
					end
				end
			end
			ST_RD: begin
				if (mem_ack_i) begin
					s_d.mreq.req = 1'b0;
					pk_push = 1'b1;
					if (s_q.ctrl.source_increment_enable) begin
						s_d.src = s_q.src + {29'h0, sbytes};
					end
					if (s_q.left != 12'h000) begin
						s_d.left = s_q.left - 12'h001;
					end
					if (sp && s_q.sb_left != 9'h000) begin
						s_d.sb_left = s_q.sb_left - 9'h001;
					end
					s_d.st = ST_RUN;
				end
			end
			ST_WR: begin
				if (mem_ack_i) begin
					s_d.mreq.req = 1'b0;
					pk_pop = 1'b1;
					if (s_q.ctrl.dest_increment_enable) begin
						s_d.dst = s_q.dst + {29'h0, dbytes};
					end
					s_d.done_cnt = s_q.done_cnt + 12'h001;
					if (dp && s_q.db_left != 9'h000) begin
						s_d.db_left = s_q.db_left - 9'h001;
					end
					s_d.st = ST_RUN;
				end
			end
			ST_LLI: begin
				if (!s_q.mreq.req) begin
					// Idle cycle between item words keeps one access per req
					s_d.mreq.req = 1'b1;
				end else if (mem_ack_i) begin
					s_d.mreq.req = 1'b0;
					s_d.lli_idx = s_q.lli_idx + 2'h1;
					s_d.mreq.addr = s_q.mreq.addr + dccf_pkg::LLI_STEP;
					case (s_q.lli_idx)
						2'h0: s_d.src = mem_rdata_i;
						2'h1: s_d.dst = mem_rdata_i;
						2'h2: s_d.lli = mem_rdata_i & 32'hFFFF_FFFC;
						default: begin
							// Whole control word reloaded
							s_d.ctrl = mem_rdata_i;
							s_d.left = mem_rdata_i[11:0];
							s_d.done_cnt = '0;
							s_d.pdone = 1'b0;
							s_d.sb_left = '0;
							s_d.db_left = '0;
						end
					endcase
					if (s_q.lli_idx == dccf_pkg::LLI_LAST_IDX) begin
						s_d.st = ST_RUN;
					end
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
	end

	// ********************************************************************
	// State register
	// ********************************************************************
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_q <= '0;
			s_q.wait_n <= 1'b1;
			s_q.ctrl <= dccf_pkg::CTRL_RST;
			s_q.src <= dccf_pkg::ADDR_RST;
			s_q.dst <= dccf_pkg::ADDR_RST;
			s_q.lli <= dccf_pkg::ADDR_RST;
			s_q.flow <= dccf_pkg::FLOW_RST;
			s_q.st <= ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state flops
	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.wait_n;
	assign mem_o = s_q.mreq;
	assign busy_o = s_q.en;

endmodule

// File: tb/dccf_mem_model.sv
// Behavioural memory on the channel's system bus
`timescale 1ns/1ps
module dccf_mem_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Request in, answer out
	input dccf_pkg::dccf_mreq_t req_i,
	input wire logic [1:0] lat_i,
	output logic ack_o,
	output logic [31:0] rdata_o
);
	logic [7:0] mem [256];
	logic [1:0] wait_q;
	logic [31:0] t;
	logic [31:0] rd_addr;
	logic [31:0] wr_addr;
	int n_rd;
	int n_wr;
	initial begin
		ack_o = 1'b0;
		rdata_o = 32'h0;
		wait_q = 2'h0;
	end
	// Each byte starts as a scrambled copy of its own address
	task automatic fill();
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
		n_rd = 0;
		n_wr = 0;
	endtask
	task automatic poke(input logic [7:0] a, input logic [31:0] w);
		for (int b = 0; b < 4; b++) mem[a + 8'(b)] = w[b*8 +: 8];
	endtask
	// Late answers by lat_i; stale data lines keep toggling
	always @(posedge clk_i) begin
		rdata_o <= ~rdata_o;
		if (srst_i || ack_o || !req_i.req) begin
			ack_o <= 1'b0;
			wait_q <= 2'h0;
		end else if (wait_q != lat_i) begin
			wait_q <= wait_q + 2'h1;
		end else begin
			ack_o <= 1'b1;
			t = 32'h0;
			for (int b = 0; b < (1 << req_i.size); b++) begin
				if (req_i.we) begin
					mem[req_i.addr[7:0] + 8'(b)] = req_i.wdata[b*8 +: 8];
				end else begin
					t[b*8 +: 8] = mem[req_i.addr[7:0] + 8'(b)];
				end
			end
			if (req_i.we) begin
				n_wr++;
				wr_addr = req_i.addr;
			end else begin
				n_rd++;
				rd_addr = req_i.addr;
				rdata_o <= t;
			end
		end
	end
endmodule

// File: tb/dccf_channel_checker.sv
// Port-level assertions for the DMA channel
`timescale 1ns/1ps
module dccf_channel_checker (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Observed ports
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input dccf_pkg::dccf_mreq_t mem_o,
	input wire logic mem_ack_i,
	input wire logic busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// ****************
	// Register bus
	// ****************
	wait_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	access_answer_a: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
	unmapped_zero_a: assert property (avs_read && avs_waitrequest &&
		avs_address > 5'h14 |=> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	reset_idle_a: assert property (disable iff (1'b0) srst_i |=>
		avs_waitrequest && !busy_o && mem_o == '0) else $error("reset state");
	// ****************
	// System bus
	// ****************
	req_hold_a: assert property (mem_o.req && !mem_ack_i |=>
		mem_o.req && $stable(mem_o)) else $error("request changed early");
	req_gap_a: assert property (mem_o.req && mem_ack_i |=> !mem_o.req)
		else $error("no idle cycle after ack");
	size_code_a: assert property (mem_o.req |-> mem_o.size != 2'h3)
		else $error("reserved size");
	word_align_a: assert property (mem_o.req && mem_o.size == 2'h2 |->
		mem_o.addr[1:0] == 2'h0) else $error("word misaligned");
	idle_quiet_a: assert property (!busy_o && !mem_o.req |=> !mem_o.req)
		else $error("access while disabled");
	// Main scenarios
	cover property (avs_write && !avs_waitrequest);
	cover property (mem_o.req && mem_o.we && mem_ack_i);
	cover property ($rose(busy_o));
endmodule

// File: tb/dccf_channel_tb_top.sv
// Self-checking bench for the DMA channel control fields
`timescale 1ns/1ps
module dccf_channel_tb_top;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	dccf_pkg::dccf_mreq_t mem_o;
	logic mem_ack_i;
	logic [31:0] mem_rdata_i;
	logic src_dreq_i = 1'b0;
	logic dst_dreq_i = 1'b0;
	logic periph_last_i = 1'b0;
	logic busy_o;
	logic [1:0] lat = 2'h0;
	int errors = 0;
	int n_tests = 0;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [11:0] nd;
	} dccf_row_t;
	// Control word, dest writes; reserved bits and codes kept 0
	dccf_row_t rows [7] = '{'{32'h0C400008, 12'h002},
		'{32'h0C089003, 12'h00C}, '{32'h0C252005, 12'h005},
		'{32'h0849B004, 12'h004}, '{32'h04464004, 12'h002},
		'{32'h0C22D007, 12'h003}, '{32'h0C4BF002, 12'h002}};

	initial forever #20 clk_i = ~clk_i;

	dccf_channel DUT (.clk_i(clk_i), .srst_i(srst_i),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .mem_o(mem_o),
		.mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
		.src_dreq_i(src_dreq_i), .dst_dreq_i(dst_dreq_i),
		.periph_last_i(periph_last_i), .busy_o(busy_o));
	dccf_mem_model mdl (.clk_i(clk_i), .srst_i(srst_i), .req_i(mem_o),
		.lat_i(lat), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

	// ****************
	// Shared tasks
	// ****************
	task automatic complete_run();
		if (errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	// One Avalon access; held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk_i);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk_i);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (k >= 50) begin
			errors++;
			complete_run();
		end
	endtask
	task automatic start(input logic [7:0] lli, input logic [31:0] c,
		input logic [2:0] flow);
		logic [31:0] q;
		bus(1'b1, dccf_pkg::OFS_SRC, 32'h40, q);
		bus(1'b1, dccf_pkg::OFS_DST, 32'h80, q);
		bus(1'b1, dccf_pkg::OFS_LLI, {24'h0, lli}, q);
		bus(1'b1, dccf_pkg::OFS_CTRL, c, q);
		bus(1'b1, dccf_pkg::OFS_CFG, {18'h0, flow, 11'h001}, q);
	endtask
	// Bounded wait for the channel to stop by itself
	task automatic wait_idle();
		for (int k = 0; busy_o !== 1'b0; k++) begin
			@(posedge clk_i);
			if (k > 4000) begin
				errors++;
				complete_run();
			end
		end
	endtask
	// A used-up wait bound counts as a mismatch and ends the run
	task automatic limit(input int k, input int n);
		if (k >= n) begin
			errors++;
			complete_run();
		end
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		logic [31:0] c;
		logic [31:0] q;
		int sb;
		int db;
		int nb;
		int k;
		int e;
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		bus(1'b0, dccf_pkg::OFS_CTRL, 32'h0, q);
		check(q, 32'h0);
		bus(1'b0, 5'h18, 32'h0, q);
		check(q, 32'h0);
		// Memory to memory rows, all widths; both, source-only and dest-only increments
		for (int r = 0; r < 7; r++) begin
			c = rows[r].ctrl;
			sb = 1 << c[19:18];
			db = 1 << c[22:21];
			lat <= 2'(r);
			mdl.fill();
			start(8'h00, c, 3'h0);
			wait_idle();
			bus(1'b0, dccf_pkg::OFS_CTRL, 32'h0, q);
			check(q, {c[31:12], rows[r].nd});
			check(mdl.n_wr, rows[r].nd);
			check(mdl.rd_addr, 32'h40 + (c[26] ? (c[11:0] - 1) * sb : 0));
			check(mdl.wr_addr, 32'h80 + (c[27] ? (rows[r].nd - 1) * db : 0));
			nb = c[27] ? rows[r].nd * db : db;
			for (int i = 0; i < nb; i++) begin
				k = c[27] ? i : (rows[r].nd - 1) * db + i;
				check(mdl.mem[8'h80 + i], (32'h40 + (c[26] ? k : k % sb)) ^ 32'h5A);
			end
			check(mdl.mem[8'h80 + nb], (32'h80 + nb) ^ 32'h5A);
		end
		// Linked list: second item reloads the whole control word
		mdl.fill();
		mdl.poke(8'hE0, 32'h40);
		mdl.poke(8'hE4, 32'hA0);
		mdl.poke(8'hE8, 32'h0);
		mdl.poke(8'hEC, 32'h0C480002);
		start(8'hE0, 32'h0C000004, 3'h0);
		wait_idle();
		bus(1'b0, dccf_pkg::OFS_CTRL, 32'h0, q);
		check(q, 32'h0C480002);
		check(mdl.n_wr, 6);
		for (int i = 0; i < 8; i++) check(mdl.mem[8'hA0 + i], (32'h40 + i) ^ 32'h5A);
		// One request pulse grants exactly one burst, then abort
		for (int cd = 0; cd < 8; cd++) begin
			for (int sd = 0; sd < 2; sd++) begin
				// Destination code 110 is left unused by software
				if (sd == 1 && cd == 6) continue;
				e = (cd == 0) ? 1 : 2 << cd;
				c = sd ? 32'h0448012C | (cd << 15) : 32'h0848012C | (cd << 12);
				lat <= 2'(cd);
				mdl.fill();
				start(8'h00, c, sd ? 3'h1 : 3'h2);
				// Request held until the burst has begun, then dropped
				src_dreq_i <= !sd;
				dst_dreq_i <= sd[0];
				k = 0;
				while (!(mem_o.req && mem_o.we == sd[0]) && k < 300) begin
					@(posedge clk_i);
					k++;
				end
				limit(k, 300);
				src_dreq_i <= 1'b0;
				dst_dreq_i <= 1'b0;
				for (k = 0; (sd ? mdl.n_wr : mdl.n_rd) < e && k < 6000; k++) @(posedge clk_i);
				limit(k, 6000);
				repeat (40) @(posedge clk_i);
				check(sd ? mdl.n_wr : mdl.n_rd, e);
				bus(1'b1, dccf_pkg::OFS_CFG, 32'h0, q);
				repeat (10) @(posedge clk_i);
			end
		end
		// Peripheral-owned flow, count zero; only the last pin ends it
		lat <= 2'h1;
		mdl.fill();
		start(8'h00, 32'h0C000000, 3'h6);
		src_dreq_i <= 1'b1;
		repeat (60) @(posedge clk_i);
		check(busy_o, 1'b1);
		periph_last_i <= 1'b1;
		wait_idle();
		src_dreq_i <= 1'b0;
		periph_last_i <= 1'b0;
		bus(1'b0, dccf_pkg::OFS_STAT, 32'h0, q);
		check(q, 32'h1 << dccf_pkg::STAT_PDONE_BIT);
		bus(1'b0, dccf_pkg::OFS_CTRL, 32'h0, q);
		check(q, {20'h0C000, 12'(mdl.n_wr)});
		check(mdl.n_rd > 0, 1'b1);
		check(mdl.n_wr, mdl.n_rd);
		// Reset in mid-run clears the control word
		start(8'h00, 32'h0C48012C, 3'h2);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		bus(1'b0, dccf_pkg::OFS_CTRL, 32'h0, q);
		check(q, 32'h0);
		check(busy_o, 1'b0);
		complete_run();
	end
endmodule

bind dccf_channel dccf_channel_checker chk (.clk_i, .srst_i, .avs_address,
	.avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .mem_o,
	.mem_ack_i, .busy_o);
